// file: iu_state_pkg.sv
// Purpose: shared constants and types for the integer unit state registers
// Assumes: 32-bit data path, eight register windows
// Notes: field positions and the PC, NPC, S and ET reset values live here; other resets are zero in the modules
package iu_state_pkg;
  localparam int XLEN = 32;
  localparam int NWIN = 8;
  localparam int CWP_W = 3;
  localparam int TT_W = 8;
  localparam int TBA_W = 20;
  localparam int WIM_W = NWIN;
  localparam int PSR_S_BIT = 7;
  localparam int PSR_PS_BIT = 6;
  localparam int PSR_ET_BIT = 5;
  localparam int TBR_TBA_LSB = 12;
  localparam int WP_IF_BIT = 0;
  localparam int WP_DL_BIT = 1;
  localparam int WP_DS_BIT = 0;
  localparam int WP_ADDR_LSB = 2;
  localparam int NUM_WP = 4;
  localparam int PROT_CNT_LSB = 9;
  localparam int CNT_W = 3;
  localparam int PROT_TCB_LSB = 2;
  localparam int TCB_W = 7;
  localparam int PROT_TE_BIT = 1;
  localparam int PROT_DI_BIT = 0;
  localparam int NPHYS = 8 + 16 * NWIN;
  localparam int PIDX_W = 8;
  localparam logic [CNT_W-1:0] CNT_MAX = 3'h7;
  localparam logic [4:0] REG_L1 = 5'h11;
  localparam logic [4:0] REG_L2 = 5'h12;
  localparam logic [XLEN-1:0] PC_RST = 32'h0000_0000;
  localparam logic [XLEN-1:0] NPC_RST = 32'h0000_0004;
  localparam logic [XLEN-1:0] INSN_BYTES = 32'h0000_0004;
  localparam logic [XLEN-1:0] WADDR_KEEP = 32'hFFFF_FFFD;
  localparam logic PSR_S_RST = 1'b1;
  localparam logic PSR_ET_RST = 1'b0;
  typedef enum logic [3:0] {
    SEL_PSR, SEL_WIM, SEL_Y, SEL_TBR, SEL_PC, SEL_NPC, SEL_PROT, SEL_WADDR, SEL_WMASK
  } sr_sel_t;
endpackage

// file: rf_if.sv
// Purpose: carrier between the state registers and the windowed register bank
// Assumes: one clock, core side drives addresses and writes
// Notes: ret_pc and ret_npc are the locals 1 and 2 of the current window
`timescale 1ns/1ns
`default_nettype none
interface rf_if;
  import iu_state_pkg::*;
  logic [4:0] rs1_addr;
  logic [4:0] rs2_addr;
  logic [4:0] wr_addr;
  logic [XLEN-1:0] rs1_data;
  logic [XLEN-1:0] rs2_data;
  logic [XLEN-1:0] wr_data;
  logic [XLEN-1:0] trap_pc;
  logic [XLEN-1:0] trap_npc;
  logic [XLEN-1:0] ret_pc;
  logic [XLEN-1:0] ret_npc;
  logic rd_en;
  logic wr_en;
  logic trap_we;
  logic inject;
  logic check_off;
  logic corr;
  logic uncorr;
  logic [CWP_W-1:0] cwp;
  logic [CWP_W-1:0] trap_win;
  logic [TCB_W-1:0] tcb;
  modport core (output rs1_addr, rs2_addr, wr_addr, wr_data, trap_pc, trap_npc, rd_en, wr_en,
    trap_we, inject, check_off, cwp, trap_win, tcb,
    input rs1_data, rs2_data, ret_pc, ret_npc, corr, uncorr);
  modport bank (input rs1_addr, rs2_addr, wr_addr, wr_data, trap_pc, trap_npc, rd_en, wr_en,
    trap_we, inject, check_off, cwp, trap_win, tcb,
    output rs1_data, rs2_data, ret_pc, ret_npc, corr, uncorr);
endinterface
`default_nettype wire

// file: win_reg_bank.sv
// Purpose: windowed general register bank with check bits
// Assumes: ins of window w are the outs of window w+1
// Notes: checking detects only; a single-bit syndrome is counted as corrected
`timescale 1ns/1ns
`default_nettype none
module win_reg_bank
  import iu_state_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Core side
  rf_if.bank rf
);
  function automatic logic [PIDX_W-1:0] phys(input logic [4:0] r, input logic [CWP_W-1:0] w);
    logic [CWP_W-1:0] ww;
    logic [3:0] off;
    ww = (r[4:3] == 2'h3) ? CWP_W'(w + 3'h1) : w;
    off = {r[4:3] == 2'h2, r[2:0]};
    phys = (r[4:3] == 2'h0) ? PIDX_W'(r) : PIDX_W'(8 + 16 * int'(ww) + int'(off));
  endfunction

  function automatic logic [TCB_W-1:0] chk(input logic [XLEN-1:0] d);
    chk = '0;
    for (int i = 0; i < XLEN; i++) chk[i % TCB_W] = chk[i % TCB_W] ^ d[i];
  endfunction

  // 2'b01 single syndrome bit, 2'b10 anything worse
  function automatic logic [1:0] err_kind(input logic [XLEN+TCB_W-1:0] e);
    logic [TCB_W-1:0] s;
    s = e[XLEN+TCB_W-1:XLEN] ^ chk(e[XLEN-1:0]);
    err_kind = (s == '0) ? 2'h0 : ((s & (s - 7'h01)) == '0) ? 2'h1 : 2'h2;
  endfunction

  // No reset on storage: software writes each entry before reading it
  logic [XLEN+TCB_W-1:0] mem_q [NPHYS];
  logic corr_q;
  logic uncorr_q;

  wire [PIDX_W-1:0] wr_idx = phys(rf.wr_addr, rf.cwp);
  wire [PIDX_W-1:0] l1_idx = phys(REG_L1, rf.trap_win);
  wire [PIDX_W-1:0] l2_idx = phys(REG_L2, rf.trap_win);
  wire [PIDX_W-1:0] rs1_idx = phys(rf.rs1_addr, rf.cwp);
  wire [PIDX_W-1:0] rs2_idx = phys(rf.rs2_addr, rf.cwp);
  wire [TCB_W-1:0] flip = rf.inject ? rf.tcb : '0;
  wire [XLEN+TCB_W-1:0] rs1_raw = (rs1_idx == '0) ? '0 : mem_q[rs1_idx];
  wire [XLEN+TCB_W-1:0] rs2_raw = (rs2_idx == '0) ? '0 : mem_q[rs2_idx];
  wire [1:0] k1 = err_kind(rs1_raw);
  wire [1:0] k2 = err_kind(rs2_raw);
  wire chk_on = rf.rd_en & ~rf.check_off;

  assign rf.rs1_data = rs1_raw[XLEN-1:0];
  assign rf.rs2_data = rs2_raw[XLEN-1:0];
  assign rf.ret_pc = mem_q[phys(REG_L1, rf.cwp)][XLEN-1:0];
  assign rf.ret_npc = mem_q[phys(REG_L2, rf.cwp)][XLEN-1:0];
  assign rf.corr = corr_q;
  assign rf.uncorr = uncorr_q;

  always_ff @(posedge core_clk_i) begin
    if (rf.wr_en && wr_idx != '0) mem_q[wr_idx] <= {chk(rf.wr_data) ^ flip, rf.wr_data};
    if (rf.trap_we) begin
      mem_q[l1_idx] <= {chk(rf.trap_pc) ^ flip, rf.trap_pc};
      mem_q[l2_idx] <= {chk(rf.trap_npc) ^ flip, rf.trap_npc};
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      corr_q <= 1'b0;
      uncorr_q <= 1'b0;
    end else begin
      corr_q <= chk_on & (k1 == 2'h1 | k2 == 2'h1);
      uncorr_q <= chk_on & (k1 == 2'h2 | k2 == 2'h2);
    end
  end
endmodule
`default_nettype wire

// file: iu_state_regs.sv
// Purpose: integer unit architectural state registers and watchpoints
// Assumes: pipeline presents one state-register access per cycle
// Notes: Contract below
// Contract
// - Processor state bit 7 set means privileged mode, clear means user mode.
// - Every trap copies the privilege bit into the previous-privilege bit 6.
// - Taking any trap clears the trap enable bit 5.
// - With traps disabled interrupts are ignored and exceptions enter error mode.
// - Window pointer decrements on trap and save, increments on restore, modulo 8.
// - Processor state, window mask and trap base are privileged-only accesses.
// - Save, restore or return into a window marked invalid raises overflow or underflow.
// - Multiply results load their upper word into the high-word register.
// - Divides take their dividend upper word from the high-word register.
// - Trap base upper 20 bits plus trap code form the trap vector.
// - Trap code written on each trap except external reset, held otherwise.
// - Trap saves program counter to local 1; return restores it.
// - Trap saves next program counter to local 2; return restores it.
// - Four watch addresses; bit 0 enables instruction fetch hits.
// - Watch mask ones include address bits in the compare, zeros exclude them.
// - Watch mask bit 1 enables load hits, bit 0 store hits.
// - Error counter counts corrected errors and saturates at seven.
// - In test mode destination check bits are XORed with the test field.
// - Protection control bit 1 enables error insertion into the register bank.
// - Protection control bit 0 disables register bank checking.
// - Global register zero always reads zero.
`timescale 1ns/1ns
`default_nettype none
module iu_state_regs
  import iu_state_pkg::*;
#(
  // Identification fields, values arbitrary
  parameter logic [3:0] IMPL_ID = 4'h0,
  parameter logic [3:0] VER_ID = 4'h0
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // State register instructions
  input wire logic sr_rd_i,
  input wire logic sr_wr_i,
  input wire sr_sel_t sr_sel_i,
  input wire logic [1:0] sr_idx_i,
  input wire logic [XLEN-1:0] sr_wdata_i,
  output logic [XLEN-1:0] sr_rdata_o,
  output logic sr_priv_fault_o,
  // Traps
  input wire logic trap_req_i,
  input wire logic trap_irq_i,
  input wire logic trap_ext_rst_i,
  input wire logic [TT_W-1:0] trap_code_i,
  output logic trap_taken_o,
  output logic error_mode_o,
  // Window operations
  input wire logic save_i,
  input wire logic restore_i,
  input wire logic rett_i,
  output logic win_ovf_o,
  output logic win_unf_o,
  // Program flow
  input wire logic pc_adv_i,
  input wire logic [XLEN-1:0] npc_target_i,
  output logic [XLEN-1:0] pc_o,
  output logic [XLEN-1:0] npc_o,
  output logic priv_o,
  // Multiply and divide
  input wire logic mul_hi_we_i,
  input wire logic [XLEN-1:0] mul_hi_i,
  output logic [XLEN-1:0] div_hi_o,
  // Watchpoints
  input wire logic fetch_vld_i,
  input wire logic [XLEN-1:0] fetch_addr_i,
  input wire logic ld_i,
  input wire logic st_i,
  input wire logic [XLEN-1:0] data_addr_i,
  output logic [NUM_WP-1:0] wp_hit_o,
  // General registers
  input wire logic rd_en_i,
  input wire logic [4:0] rs1_addr_i,
  input wire logic [4:0] rs2_addr_i,
  input wire logic wr_en_i,
  input wire logic [4:0] wr_addr_i,
  input wire logic [XLEN-1:0] wr_data_i,
  output logic [XLEN-1:0] rs1_data_o,
  output logic [XLEN-1:0] rs2_data_o,
  output logic rf_corr_o,
  output logic rf_uncorr_o
);
  function automatic logic wp_match(input logic [XLEN-1:0] a, input logic [XLEN-1:0] wa,
                                    input logic [XLEN-1:0] wm);
    wp_match = (((a ^ wa) & wm) >> WP_ADDR_LSB) == '0;
  endfunction

  logic s_q;
  logic ps_q;
  logic et_q;
  logic [CWP_W-1:0] cwp_q;
  logic [WIM_W-1:0] wim_q;
  logic [XLEN-1:0] y_q;
  logic [TBA_W-1:0] tba_q;
  logic [TT_W-1:0] tt_q;
  logic [XLEN-1:0] pc_q;
  logic [XLEN-1:0] npc_q;
  logic [CNT_W-1:0] cnt_q;
  logic [TCB_W-1:0] tcb_q;
  logic te_q;
  logic di_q;
  logic err_q;
  logic taken_q;
  logic fault_q;
  logic ovf_q;
  logic unf_q;
  logic [XLEN-1:0] rdata_q;
  logic [XLEN-1:0] waddr_q [NUM_WP];
  logic [XLEN-1:0] wmask_q [NUM_WP];
  logic [NUM_WP-1:0] hit_q;

  rf_if rf();

  win_reg_bank u_bank (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .rf(rf.bank)
  );

  // Access checks and write strobes
  wire priv_sel = (sr_sel_i == SEL_PSR) | (sr_sel_i == SEL_WIM) | (sr_sel_i == SEL_TBR);
  wire acc_bad = (sr_rd_i | sr_wr_i) & priv_sel & ~s_q;
  wire wr_ok = sr_wr_i & ~acc_bad;
  wire wr_psr = wr_ok & (sr_sel_i == SEL_PSR);
  wire wr_wim = wr_ok & (sr_sel_i == SEL_WIM);
  wire wr_y = wr_ok & (sr_sel_i == SEL_Y);
  wire wr_tbr = wr_ok & (sr_sel_i == SEL_TBR);
  wire wr_prot = wr_ok & (sr_sel_i == SEL_PROT);
  wire wr_wa = wr_ok & (sr_sel_i == SEL_WADDR);
  wire wr_wm = wr_ok & (sr_sel_i == SEL_WMASK);

  // Trap acceptance; an external reset request is honoured even with traps off
  wire trap_take = trap_req_i & ~err_q & (et_q | trap_ext_rst_i);
  wire trap_fatal = trap_req_i & ~err_q & ~et_q & ~trap_irq_i & ~trap_ext_rst_i;
  wire [XLEN-1:0] vec = {tba_q, trap_code_i, 4'h0};

  // Window movement
  wire [CWP_W-1:0] cwp_dn = cwp_q - 3'h1;
  wire [CWP_W-1:0] cwp_up = cwp_q + 3'h1;
  wire save_go = save_i & ~trap_take;
  wire rest_go = (restore_i | rett_i) & ~trap_take;
  wire save_bad = save_go & wim_q[cwp_dn];
  wire rest_bad = rest_go & wim_q[cwp_up];
  wire rett_ok = rett_i & ~trap_take & ~rest_bad;

  // Next state, trap first, then window moves, then software writes
  wire [CWP_W-1:0] cwp_d = trap_take ? cwp_dn :
    (save_go & ~save_bad) ? cwp_dn :
    (rest_go & ~rest_bad) ? cwp_up :
    wr_psr ? sr_wdata_i[CWP_W-1:0] : cwp_q;
  wire s_d = trap_take ? 1'b1 : rett_ok ? ps_q : wr_psr ? sr_wdata_i[PSR_S_BIT] : s_q;
  wire ps_d = trap_take ? s_q : wr_psr ? sr_wdata_i[PSR_PS_BIT] : ps_q;
  wire et_d = trap_take ? 1'b0 : rett_ok ? 1'b1 :
    wr_psr ? sr_wdata_i[PSR_ET_BIT] : et_q;
  wire [TT_W-1:0] tt_d = (trap_take & ~trap_ext_rst_i) ? trap_code_i : tt_q;
  wire [XLEN-1:0] pc_d = trap_take ? vec : rett_ok ? rf.ret_pc :
    pc_adv_i ? npc_q : pc_q;
  wire [XLEN-1:0] npc_d = trap_take ? vec + INSN_BYTES : rett_ok ? rf.ret_npc :
    pc_adv_i ? npc_target_i : npc_q;
  wire [XLEN-1:0] y_d = mul_hi_we_i ? mul_hi_i : wr_y ? sr_wdata_i : y_q;

  // A correction in the same cycle as a write still counts
  wire [CNT_W-1:0] cnt_base = wr_prot ? sr_wdata_i[PROT_CNT_LSB +: CNT_W] : cnt_q;
  wire [CNT_W-1:0] cnt_d = (rf.corr && cnt_base != CNT_MAX) ?
    cnt_base + 3'h1 : cnt_base;

  // Read selection
  wire [XLEN-1:0] psr_rd = {IMPL_ID, VER_ID, 16'h0000, s_q, ps_q, et_q, 2'h0, cwp_q};
  wire [XLEN-1:0] tbr_rd = {tba_q, tt_q, 4'h0};
  wire [XLEN-1:0] prot_rd = {20'h00000, cnt_q, tcb_q, te_q, di_q};
  wire [XLEN-1:0] rd_mux = (sr_sel_i == SEL_PSR) ? psr_rd :
    (sr_sel_i == SEL_WIM) ? {24'h000000, wim_q} :
    (sr_sel_i == SEL_Y) ? y_q :
    (sr_sel_i == SEL_TBR) ? tbr_rd :
    (sr_sel_i == SEL_PC) ? pc_q :
    (sr_sel_i == SEL_NPC) ? npc_q :
    (sr_sel_i == SEL_PROT) ? prot_rd :
    (sr_sel_i == SEL_WADDR) ? waddr_q[sr_idx_i] :
    (sr_sel_i == SEL_WMASK) ? wmask_q[sr_idx_i] : '0;

  // Register bank hookup
  assign rf.rs1_addr = rs1_addr_i;
  assign rf.rs2_addr = rs2_addr_i;
  assign rf.rd_en = rd_en_i;
  assign rf.wr_en = wr_en_i;
  assign rf.wr_addr = wr_addr_i;
  assign rf.wr_data = wr_data_i;
  assign rf.cwp = cwp_q;
  assign rf.trap_we = trap_take;
  assign rf.trap_win = cwp_dn;
  assign rf.trap_pc = pc_q;
  assign rf.trap_npc = npc_q;
  assign rf.inject = te_q;
  assign rf.tcb = tcb_q;
  assign rf.check_off = di_q;

  // Outputs
  assign sr_rdata_o = rdata_q;
  assign sr_priv_fault_o = fault_q;
  assign trap_taken_o = taken_q;
  assign error_mode_o = err_q;
  assign win_ovf_o = ovf_q;
  assign win_unf_o = unf_q;
  assign pc_o = pc_q;
  assign npc_o = npc_q;
  assign priv_o = s_q;
  assign div_hi_o = y_q;
  assign wp_hit_o = hit_q;
  assign rs1_data_o = rf.rs1_data;
  assign rs2_data_o = rf.rs2_data;
  assign rf_corr_o = rf.corr;
  assign rf_uncorr_o = rf.uncorr;

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= PSR_S_RST;
      ps_q <= 1'b0;
      et_q <= PSR_ET_RST;
      cwp_q <= '0;
      wim_q <= '0;
      y_q <= '0;
      tba_q <= '0;
      tt_q <= '0;
    end else begin
      s_q <= s_d;
      ps_q <= ps_d;
      et_q <= et_d;
      cwp_q <= cwp_d;
      wim_q <= wr_wim ? sr_wdata_i[WIM_W-1:0] : wim_q;
      y_q <= y_d;
      tba_q <= wr_tbr ? sr_wdata_i[XLEN-1:TBR_TBA_LSB] : tba_q;
      tt_q <= tt_d;
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_q <= PC_RST;
      npc_q <= NPC_RST;
      cnt_q <= '0;
      tcb_q <= '0;
      te_q <= 1'b0;
      di_q <= 1'b0;
    end else begin
      pc_q <= pc_d;
      npc_q <= npc_d;
      cnt_q <= cnt_d;
      tcb_q <= wr_prot ? sr_wdata_i[PROT_TCB_LSB +: TCB_W] : tcb_q;
      te_q <= wr_prot ? sr_wdata_i[PROT_TE_BIT] : te_q;
      di_q <= wr_prot ? sr_wdata_i[PROT_DI_BIT] : di_q;
    end
  end

  // Error mode is left only through reset
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      err_q <= 1'b0;
      taken_q <= 1'b0;
      fault_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      err_q <= err_q | trap_fatal;
      taken_q <= trap_take;
      fault_q <= acc_bad;
      ovf_q <= save_bad;
      unf_q <= rest_bad;
      rdata_q <= (sr_rd_i & ~acc_bad) ? rd_mux : rdata_q;
    end
  end

  // Watchpoint pairs
  for (genvar i = 0; i < NUM_WP; i++) begin : g_wp
    wire sel = (sr_idx_i == 2'(i));
    wire if_hit = fetch_vld_i & waddr_q[i][WP_IF_BIT] &
      wp_match(fetch_addr_i, waddr_q[i], wmask_q[i]);
    wire d_hit = ((ld_i & wmask_q[i][WP_DL_BIT]) | (st_i & wmask_q[i][WP_DS_BIT])) &
      wp_match(data_addr_i, waddr_q[i], wmask_q[i]);
    always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
        waddr_q[i] <= '0;
        wmask_q[i] <= '0;
        hit_q[i] <= 1'b0;
      end else begin
        waddr_q[i] <= (wr_wa & sel) ? (sr_wdata_i & WADDR_KEEP) : waddr_q[i];
        wmask_q[i] <= (wr_wm & sel) ? sr_wdata_i : wmask_q[i];
        hit_q[i] <= if_hit | d_hit;
      end
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  ps_copy_a: assert property (trap_take |=> ps_q == $past(s_q))
    else $error("previous privilege not copied on trap");
  et_clear_a: assert property (trap_take |=> !et_q && s_q && trap_taken_o)
    else $error("trap enable not cleared on trap");
  irq_ignore_a: assert property (trap_req_i && trap_irq_i && !et_q && !trap_ext_rst_i
    |=> !trap_taken_o && $stable(cwp_q) && $stable(pc_q))
    else $error("interrupt taken while traps disabled");
  err_enter_a: assert property (trap_fatal |=> error_mode_o [*3])
    else $error("exception with traps off did not halt");
  cwp_trap_a: assert property (trap_take |=> cwp_q == 3'($past(cwp_q) - 3'h1))
    else $error("window pointer not decremented on trap");
  priv_check_a: assert property (sr_wr_i && priv_sel && !s_q
    |=> sr_priv_fault_o && $stable(psr_rd) && $stable(tba_q))
    else $error("user access to privileged register not refused");
  wim_block_a: assert property (save_go && wim_q[cwp_dn]
    |=> win_ovf_o && cwp_q == $past(cwp_q))
    else $error("save into invalid window not trapped");
  y_load_a: assert property (mul_hi_we_i |=> div_hi_o == $past(mul_hi_i))
    else $error("high word not loaded by multiply");
  vector_a: assert property (trap_take |=> pc_o == {$past(tba_q), $past(trap_code_i), 4'h0}
    && npc_o == pc_o + INSN_BYTES)
    else $error("trap vector wrong");
  tt_hold_a: assert property (!(trap_take && !trap_ext_rst_i) |=> $stable(tt_q))
    else $error("trap code changed without a trap");
  cnt_sat_a: assert property (cnt_q == CNT_MAX && !wr_prot |=> cnt_q == CNT_MAX)
    else $error("error counter wrapped");

  trap_seen_c: cover property (trap_take ##1 trap_taken_o);
  ovf_seen_c: cover property (save_bad ##1 win_ovf_o);
  rett_seen_c: cover property (trap_take ##[1:20] rett_ok);
  cnt_full_c: cover property (cnt_q == CNT_MAX);
endmodule
`default_nettype wire

// file: iu_state_regs_test.sv
// Purpose: self-checking bench for the integer unit state registers
// Assumes: one operation at a time, with an idle cycle after each one driven by a task
// Notes: register reads are compared by a monitor from a queue of expected words
`timescale 1ns/1ns
`default_nettype none
module iu_state_regs_test;
  import iu_state_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic sr_rd_i = 1'b0, sr_wr_i = 1'b0, trap_req_i = 1'b0, trap_irq_i = 1'b0;
  logic trap_ext_rst_i = 1'b0, save_i = 1'b0, restore_i = 1'b0, rett_i = 1'b0;
  logic pc_adv_i = 1'b0, mul_hi_we_i = 1'b0, fetch_vld_i = 1'b0, ld_i = 1'b0, st_i = 1'b0;
  logic rd_en_i = 1'b0, wr_en_i = 1'b0;
  sr_sel_t sr_sel_i = SEL_PSR;
  logic [1:0] sr_idx_i = 2'h0;
  logic [7:0] trap_code_i = 8'h00;
  logic [4:0] rs1_addr_i = 5'h00, rs2_addr_i = 5'h00, wr_addr_i = 5'h00;
  logic [31:0] sr_wdata_i = '0, npc_target_i = '0, mul_hi_i = '0, fetch_addr_i = '0;
  logic [31:0] data_addr_i = '0, wr_data_i = '0;
  logic [31:0] sr_rdata_o, pc_o, npc_o, div_hi_o, rs1_data_o, rs2_data_o;
  logic sr_priv_fault_o, trap_taken_o, error_mode_o, win_ovf_o, win_unf_o, priv_o;
  logic rf_corr_o, rf_uncorr_o;
  logic [3:0] wp_hit_o;
  int checks = 0;
  int fails = 0;
  logic [31:0] seed = 32'h84C38BE8;
  logic [31:0] exp_q[$];
  logic seen = 1'b0;

  iu_state_regs DUT (
    .core_clk_i, .rst_i, .sr_rd_i, .sr_wr_i, .sr_sel_i, .sr_idx_i, .sr_wdata_i,
    .sr_rdata_o, .sr_priv_fault_o, .trap_req_i, .trap_irq_i, .trap_ext_rst_i,
    .trap_code_i, .trap_taken_o, .error_mode_o, .save_i, .restore_i, .rett_i,
    .win_ovf_o, .win_unf_o, .pc_adv_i, .npc_target_i, .pc_o, .npc_o, .priv_o,
    .mul_hi_we_i, .mul_hi_i, .div_hi_o, .fetch_vld_i, .fetch_addr_i, .ld_i, .st_i,
    .data_addr_i, .wp_hit_o, .rd_en_i, .rs1_addr_i, .rs2_addr_i, .wr_en_i, .wr_addr_i,
    .wr_data_i, .rs1_data_o, .rs2_data_o, .rf_corr_o, .rf_uncorr_o
  );

  always #5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task automatic tick();
    @(negedge core_clk_i);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic finish_test();
    $display("Counts: checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Read data lands one edge after the request, so the monitor looks one cycle later
  always @(posedge core_clk_i) seen <= sr_rd_i;
  always @(negedge core_clk_i) begin
    if (seen) begin
      chk("sr_rdata", exp_q.pop_front(), sr_rdata_o);
    end
  end

  task automatic wr(input sr_sel_t s, input logic [1:0] i, input logic [31:0] d, input logic f);
    sr_wr_i = 1'b1;
    sr_sel_i = s;
    sr_idx_i = i;
    sr_wdata_i = d;
    tick();
    sr_wr_i = 1'b0;
    chk("priv_fault", 32'(f), 32'(sr_priv_fault_o));
    tick();
  endtask

  task automatic rd(input sr_sel_t s, input logic [1:0] i, input logic [31:0] e);
    sr_rd_i = 1'b1;
    sr_sel_i = s;
    sr_idx_i = i;
    exp_q.push_back(e);
    tick();
    sr_rd_i = 1'b0;
    tick();
  endtask

  task automatic trap(input logic q, input logic x, input logic [7:0] c, input logic t);
    trap_req_i = 1'b1;
    trap_irq_i = q;
    trap_ext_rst_i = x;
    trap_code_i = c;
    tick();
    trap_req_i = 1'b0;
    chk("trap_taken", 32'(t), 32'(trap_taken_o));
    tick();
  endtask

  task automatic wacc(input logic [2:0] k, input logic [31:0] a, input logic [3:0] h);
    {fetch_vld_i, ld_i, st_i} = k;
    fetch_addr_i = a;
    data_addr_i = a;
    tick();
    {fetch_vld_i, ld_i, st_i} = 3'h0;
    chk("wp_hit", 32'(h), 32'(wp_hit_o));
    tick();
  endtask

  task automatic rw(input logic [4:0] a, input logic [31:0] d);
    wr_en_i = 1'b1;
    wr_addr_i = a;
    wr_data_i = d;
    tick();
    wr_en_i = 1'b0;
    tick();
  endtask

  initial begin
    repeat (5000) @(posedge core_clk_i);
    fails++;
    finish_test();
  end

  initial begin
    repeat (10) tick();
    rst_i = 1'b0;
    tick();
    rd(SEL_PSR, 2'h0, 32'h0000_0080);
    rd(SEL_NPC, 2'h0, NPC_RST);
    seed = xs(seed);
    wr(SEL_Y, 2'h0, seed, 1'b0);
    rd(SEL_Y, 2'h0, seed);
    chk("div_hi", seed, div_hi_o);
    seed = xs(seed);
    mul_hi_we_i = 1'b1;
    mul_hi_i = seed;
    tick();
    mul_hi_we_i = 1'b0;
    chk("div_hi", seed, div_hi_o);
    wr(SEL_PSR, 2'h0, 32'h0000_00BB, 1'b0);
    rd(SEL_PSR, 2'h0, 32'h0000_00A3);
    wr(SEL_TBR, 2'h0, 32'h1234_5FFF, 1'b0);
    rd(SEL_TBR, 2'h0, 32'h1234_5000);
    trap(1'b0, 1'b0, 8'h05, 1'b1);
    chk("pc", 32'h1234_5050, pc_o);
    rs1_addr_i = REG_L1;
    rs2_addr_i = REG_L2;
    rd(SEL_PSR, 2'h0, 32'h0000_00C2);
    rd(SEL_TBR, 2'h0, 32'h1234_5050);
    chk("local1", PC_RST, rs1_data_o);
    chk("local2", NPC_RST, rs2_data_o);
    rett_i = 1'b1;
    tick();
    rett_i = 1'b0;
    chk("pc", PC_RST, pc_o);
    chk("npc", NPC_RST, npc_o);
    // Return restores s from ps and leaves ps itself untouched
    rd(SEL_PSR, 2'h0, 32'h0000_00E3);
    pc_adv_i = 1'b1;
    npc_target_i = 32'h0000_0040;
    tick();
    pc_adv_i = 1'b0;
    chk("pc", NPC_RST, pc_o);
    chk("npc", 32'h0000_0040, npc_o);
    // Register bank: r0, injected check-bit error, saturation and disable
    wr(SEL_PROT, 2'h0, 32'hFFFF_FFFF, 1'b0);
    rd(SEL_PROT, 2'h0, 32'h0000_0FFF);
    wr(SEL_PROT, 2'h0, 32'h0000_0000, 1'b0);
    rw(5'h00, 32'hFFFF_FFFF);
    seed = xs(seed);
    rw(5'h01, seed);
    wr(SEL_PROT, 2'h0, 32'h0000_0006, 1'b0);
    rw(5'h02, seed);
    rs2_addr_i = 5'h00;
    rd_en_i = 1'b1;
    for (int k = 0; k < 10; k++) begin
      rs1_addr_i = (k == 9) ? 5'h01 : 5'h02;
      tick();
      chk("rf_corr", (k == 9) ? 32'h0 : 32'h1, 32'(rf_corr_o));
    end
    rd_en_i = 1'b0;
    chk("rs2_data", 32'h0, rs2_data_o);
    chk("rf_uncorr", 32'h0, 32'(rf_uncorr_o));
    tick();
    rd(SEL_PROT, 2'h0, 32'h0000_0E06);
    wr(SEL_PROT, 2'h0, 32'h0000_0007, 1'b0);
    rs1_addr_i = 5'h02;
    rd_en_i = 1'b1;
    tick();
    rd_en_i = 1'b0;
    chk("rf_corr", 32'h0, 32'(rf_corr_o));
    chk("rs1_data", seed, rs1_data_o);
    // Two flipped check bits must be reported as uncorrectable
    wr(SEL_PROT, 2'h0, 32'h0000_000E, 1'b0);
    rw(5'h03, seed);
    rs1_addr_i = 5'h03;
    rd_en_i = 1'b1;
    tick();
    rd_en_i = 1'b0;
    chk("rf_uncorr", 32'h1, 32'(rf_uncorr_o));
    chk("rf_corr", 32'h0, 32'(rf_corr_o));
    // Watchpoint pair 2
    wr(SEL_WADDR, 2'h2, 32'h0000_1003, 1'b0);
    rd(SEL_WADDR, 2'h2, 32'h0000_1001);
    wr(SEL_WMASK, 2'h2, 32'hFFFF_FFFE, 1'b0);
    wacc(3'h4, 32'h0000_1000, 4'h4);
    wacc(3'h2, 32'h0000_1003, 4'h4);
    wacc(3'h1, 32'h0000_1000, 4'h0);
    wacc(3'h4, 32'h0000_1004, 4'h0);
    wr(SEL_WMASK, 2'h2, 32'hFFFF_FFF2, 1'b0);
    wacc(3'h4, 32'h0000_100C, 4'h4);
    // Windows, user mode and disabled traps
    wr(SEL_WIM, 2'h0, 32'hFFFF_FF40, 1'b0);
    rd(SEL_WIM, 2'h0, 32'h0000_0040);
    wr(SEL_PSR, 2'h0, 32'h0000_0020, 1'b0);
    chk("priv", 32'h0, 32'(priv_o));
    wr(SEL_PSR, 2'h0, 32'h0000_0080, 1'b1);
    trap(1'b0, 1'b0, 8'h07, 1'b1);
    rd(SEL_PSR, 2'h0, 32'h0000_0087);
    save_i = 1'b1;
    tick();
    save_i = 1'b0;
    chk("win_ovf", 32'h1, 32'(win_ovf_o));
    tick();
    wr(SEL_PSR, 2'h0, 32'h0000_0085, 1'b0);
    restore_i = 1'b1;
    tick();
    restore_i = 1'b0;
    chk("win_unf", 32'h1, 32'(win_unf_o));
    tick();
    rd(SEL_PSR, 2'h0, 32'h0000_0085);
    trap(1'b1, 1'b0, 8'h11, 1'b0);
    trap(1'b0, 1'b1, 8'h22, 1'b1);
    rd(SEL_TBR, 2'h0, 32'h1234_5070);
    trap(1'b0, 1'b0, 8'h09, 1'b0);
    chk("error_mode", 32'h1, 32'(error_mode_o));
    rst_i = 1'b1;
    tick();
    rst_i = 1'b0;
    tick();
    chk("error_mode", 32'h0, 32'(error_mode_o));
    rd(SEL_PSR, 2'h0, 32'h0000_0080);
    tick();
    chk("queue_left", 32'h0, 32'(exp_q.size()));
    finish_test();
  end
endmodule
`default_nettype wire
